// *** logic/bdc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: Enable low turns all switches off.
// RULE2: Both inputs low gives dump state.
// RULE3: A low, B high gives negative.
// RULE4: A high, B low gives positive.
// RULE5: Never drive both inputs high enabled.
// RULE6: Hold sleep low during supply ramp.
// RULE7: Raise sleep, keep enable low, settle.
// RULE8: Raise enable last.
// RULE9: Enable or sleep low floats outputs.
// RULE10: Stop drive inputs before supply removal.
// RULE11: Warning pin low above 130 C.
// RULE12: Overcurrent and overheat are faults.
// RULE13: Fault switches off all transistors.
// RULE14: Fault pin pulled low on fault.
// RULE15: Latched mode rearm by high-low-high enable.
// RULE16: Auto mode: fault pulls enable, restarts.
// RULE17: Auto mode repeats while fault persists.
// RULE18: Undervoltage lockout recovers itself.
// RULE19: Two drive signals per channel.
// RULE20: Channels decode independently.
module bdc_host #(
  parameter int SETTLE_CNT = bdc_pkg::SETTLE_CYCLES,
  parameter int TOGGLE_CNT = bdc_pkg::TOGGLE_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic [3:0]         addr,
  input  wire logic [7:0]         wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic [7:0]              rdata,
  input  wire logic               supply_good,
  input  wire logic               fault_pin_n,
  input  wire logic               overtemp_alert_pin_n,
  output bdc_pkg::bdc_drive_t     drive_inputs,
  output bdc_pkg::bdc_ctl_t       ctl
);
  import bdc_pkg::*;

  // Two-stage synchronisers for the open-drain pins and supply flag
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic       fault_seen;     // Synchronised fault, active high
  logic       warn_seen;      // Synchronised warning, active high
  logic       supply_ok;      // Synchronised supply flag

  // Software state
  logic [2:0] ctrl;
  logic [2:0] next_ctrl;
  logic [3:0] drive_req;
  logic [3:0] next_drive_req;
  logic       fault_sticky;
  logic       next_fault_sticky;
  logic [7:0] next_rdata;

  // Sequencer state
  bdc_state_t           state;
  bdc_state_t           next_state;
  logic [CNT_W-1:0]     cnt;
  logic [CNT_W-1:0]     next_cnt;
  bdc_drive_t           next_drive;
  bdc_ctl_t             next_ctl;

  // Pick A and B, replacing the illegal pair by dump
  function automatic logic [1:0] safe_pair(input logic a, input logic b);
    safe_pair = (a & b) ? 2'b00 : {a, b}; // see RULE5
  endfunction

  // Synchroniser flops only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {supply_good, ~overtemp_alert_pin_n, ~fault_pin_n};
      sync2 <= sync1;
    end
  end
  assign fault_seen = sync2[0];     // see RULE14
  assign warn_seen  = sync2[1];     // see RULE11
  assign supply_ok  = sync2[2];

  // Register writes, status capture and read data
  always_comb begin
    next_ctrl         = ctrl;
    next_drive_req    = drive_req;
    next_fault_sticky = fault_sticky;
    next_rdata        = 8'h00;
    if (wr && addr == REG_CTRL) begin
      next_ctrl = wdata[2:0];
    end
    if (wr && addr == REG_DRIVE) begin
      next_drive_req = wdata[3:0];
    end
    // Clear on write, but a fault in the same cycle wins
    if (wr && addr == REG_STATUS && wdata[ST_FAULT_BIT]) begin
      next_fault_sticky = 1'b0;
    end
    if (fault_seen) begin
      next_fault_sticky = 1'b1;     // see RULE12
    end
    if (rd) begin
      case (addr)
        REG_CTRL:   next_rdata = {5'h00, ctrl};
        REG_DRIVE:  next_rdata = {4'h0, drive_req};
        REG_STATUS: next_rdata = {1'b0, state, 2'b00, warn_seen, fault_sticky};
        default:    next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl         <= CTRL_RESET;
      drive_req    <= DRIVE_RESET;
      fault_sticky <= 1'b0;
      rdata        <= 8'h00;
    end else begin
      ctrl         <= next_ctrl;
      drive_req    <= next_drive_req;
      fault_sticky <= next_fault_sticky;
      rdata        <= next_rdata;
    end
  end

  // Power sequencer and fault handling
  always_comb begin
    logic [1:0] p0;
    logic [1:0] p1;
    p0         = safe_pair(drive_req[0], drive_req[2]);
    p1         = safe_pair(drive_req[1], drive_req[3]);
    next_state = state;
    next_cnt   = cnt;
    next_ctl   = '{sleep_n: 1'b0, enable: 1'b0};
    next_drive = '0;
    case (state)
      // Sleep held low while supplies ramp
      ST_OFF: begin
        next_cnt = '0;
        if (ctrl[CTRL_RUN_BIT] && supply_ok) begin
          next_state = ST_SLEEP;    // see RULE6
        end
      end
      // Sleep released, enable kept low until regulators settle
      ST_SLEEP: begin
        next_ctl.sleep_n = 1'b1;    // see RULE7
        next_cnt = cnt + 1'b1;
        if (!ctrl[CTRL_RUN_BIT] || !supply_ok) begin
          next_state = ST_OFF;
        end else if (cnt >= CNT_W'(SETTLE_CNT - 1)) begin
          next_state = ST_RUN;
          next_cnt   = '0;
        end
      end
      // Enable last, drive per channel on the same edge
      ST_RUN: begin
        next_ctl = '{sleep_n: 1'b1, enable: 1'b1};  // see RULE8
        next_drive.drive_in_a = {p1[1], p0[1]};     // see RULE19
        next_drive.drive_in_b = {p1[0], p0[0]};     // see RULE20
        if (!ctrl[CTRL_RUN_BIT] || !supply_ok) begin
          // Inputs stop before the supply may go
          next_drive = '0;                          // see RULE10
          next_state = ST_OFF;
        end else if (fault_seen && !ctrl[CTRL_AUTO_BIT]) begin
          next_drive = '0;
          next_state = ST_FAULT;                    // see RULE15
        end
      end
      // Latched fault: enable low, wait for software retry
      ST_FAULT: begin
        next_ctl.sleep_n = 1'b1;
        next_cnt = '0;
        // Supply loss must drop sleep here too, or the bridge stays half awake
        if (!ctrl[CTRL_RUN_BIT] || !supply_ok) begin
          next_state = ST_OFF;
        end else if (ctrl[CTRL_RETRY_BIT] && !fault_seen) begin
          next_state = ST_REARM;
        end
      end
      // Hold enable low for the toggle time, then raise it again
      ST_REARM: begin
        next_ctl.sleep_n = 1'b1;
        next_cnt = cnt + 1'b1;
        if (!ctrl[CTRL_RUN_BIT] || !supply_ok) begin
          next_state = ST_OFF;
          next_cnt   = '0;
        end else if (cnt >= CNT_W'(TOGGLE_CNT - 1)) begin
          next_state = ST_RUN;                      // see RULE15
          next_cnt   = '0;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state        <= ST_OFF;
      cnt          <= '0;
      ctl          <= '{sleep_n: 1'b0, enable: 1'b0};
      drive_inputs <= '0;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      ctl          <= next_ctl;
      drive_inputs <= next_drive;
    end
  end

  // Checks on the pin sequencing
  no_both_high_a: assert property (@(posedge clk) disable iff (reset) // see RULE5
    (drive_inputs.drive_in_a & drive_inputs.drive_in_b) == 2'b00)
    else $error("both drive inputs high");
  enable_order_a: assert property (@(posedge clk) disable iff (reset) // see RULE8
    $rose(ctl.enable) |-> ctl.sleep_n && $past(ctl.sleep_n))
    else $error("enable raised before sleep released");
  idle_quiet_a: assert property (@(posedge clk) disable iff (reset) // see RULE10
    !ctl.enable |-> drive_inputs == '0)
    else $error("drive inputs active while disabled");
  sleep_first_a: assert property (@(posedge clk) disable iff (reset) // see RULE6
    !supply_ok ##1 !supply_ok |-> ##2 !ctl.sleep_n)
    else $error("sleep released without supply");
  latched_off_a: assert property (@(posedge clk) disable iff (reset) // see RULE15
    state == ST_FAULT |=> !ctl.enable)
    else $error("enable high in latched fault");
  settle_time_a: assert property (@(posedge clk) disable iff (reset) // see RULE7
    $rose(ctl.sleep_n) |-> !ctl.enable [*3])
    else $error("enable raised too soon");
  cover_run_c:   cover property (@(posedge clk) disable iff (reset) state == ST_RUN);
  cover_fault_c: cover property (@(posedge clk) disable iff (reset) state == ST_FAULT);
  cover_rearm_c: cover property (@(posedge clk) disable iff (reset)
    state == ST_REARM ##1 state == ST_RUN);
endmodule
`default_nettype wire

// *** logic/bdc_pkg.sv ***
package bdc_pkg;
  // Register offsets of the controller's own command port
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_DRIVE  = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  // Control register field positions
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_AUTO_BIT  = 1;
  localparam int CTRL_RETRY_BIT = 2;
  // Status register field positions
  localparam int ST_FAULT_BIT  = 0;
  localparam int ST_WARN_BIT   = 1;
  localparam int ST_STATE_LSB  = 4;
  // Values after reset
  localparam logic [2:0] CTRL_RESET  = 3'h0;
  localparam logic [3:0] DRIVE_RESET = 4'h0;
  // Sequencing times and their cycle counts at 50 MHz
  localparam int CLK_HZ        = 50_000_000;
  localparam int SETTLE_US     = 100;
  localparam int SETTLE_CYCLES = (SETTLE_US * (CLK_HZ / 1_000_000));
  localparam int TOGGLE_US     = 10;
  localparam int TOGGLE_CYCLES = (TOGGLE_US * (CLK_HZ / 1_000_000));
  localparam int CNT_W         = 16;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_SLEEP  = 3'b001,
    ST_WAKE   = 3'b010,
    ST_RUN    = 3'b011,
    ST_FAULT  = 3'b100,
    ST_REARM  = 3'b101
  } bdc_state_t;

  // Drive pins of both channels
  typedef struct packed {
    logic [1:0] drive_in_a;
    logic [1:0] drive_in_b;
  } bdc_drive_t;

  // Control pins toward the bridge
  typedef struct packed {
    logic sleep_n;
    logic enable;
  } bdc_ctl_t;
endpackage

// *** verif/bdc_bridge_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behavioural power stage seen from the host, latched-shutdown wiring
module bdc_bridge_model (
  input  wire bdc_pkg::bdc_drive_t drive_inputs,
  input  wire bdc_pkg::bdc_ctl_t   ctl,
  input  wire logic                fault_req,
  input  wire logic                hot,
  output logic                     fault_pin_n,
  output logic                     overtemp_alert_pin_n,
  output logic [7:0]               sw
);
  logic lat;  // Latched fault state
  logic on;   // Bridges allowed to switch
  // Fault latches; only an enable low clears it once the cause is gone
  always @* begin
    if (fault_req) lat = 1'b1;
    else if (!ctl.enable) lat = 1'b0;
  end
  // Open drain with pull-up: released reads high
  assign fault_pin_n = !lat;
  assign overtemp_alert_pin_n = !hot;
  assign on = ctl.enable & ctl.sleep_n & !lat;
  // Per-channel switch decode {upper_a, upper_b, lower_a, lower_b}
  always @* begin
    for (int c = 0; c < 2; c++) begin
      if (!on) sw[c*4+:4] = 4'h0;
      else if (drive_inputs.drive_in_a[c] & drive_inputs.drive_in_b[c]) sw[c*4+:4] = 4'hc;
      else if (drive_inputs.drive_in_a[c]) sw[c*4+:4] = 4'h9;
      else if (drive_inputs.drive_in_b[c]) sw[c*4+:4] = 4'h6;
      else sw[c*4+:4] = 4'h3;
    end
  end
endmodule
`default_nettype wire

// *** verif/bdc_host_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module bdc_host_tb;
  import bdc_pkg::*;
  logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, supply_good = 1'b1;
  logic fault_req = 1'b0, hot = 1'b0, fault_pin_n, overtemp_alert_pin_n;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h0, rdata, sw, r;
  bdc_drive_t  drive_inputs;
  bdc_ctl_t    ctl;
  int          fails = 0, n_tests = 0;
  always #10 clk = ~clk;
  // Short counts keep the run brief
  bdc_host #(.SETTLE_CNT(8), .TOGGLE_CNT(4)) bdc_host_inst (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .supply_good(supply_good),
    .fault_pin_n(fault_pin_n), .overtemp_alert_pin_n(overtemp_alert_pin_n),
    .drive_inputs(drive_inputs), .ctl(ctl));
  bdc_bridge_model bdc_bridge_model_inst (.drive_inputs(drive_inputs), .ctl(ctl),
    .fault_req(fault_req), .hot(hot), .fault_pin_n(fault_pin_n),
    .overtemp_alert_pin_n(overtemp_alert_pin_n), .sw(sw));
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(logic [3:0] a, output logic [7:0] d);
    addr <= a; rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  // Bounded wait for a control pin pattern; running out ends the run
  task automatic wait_ctl(logic [1:0] exp);
    int i;
    for (i = 0; i < 100 && ctl !== exp; i++) begin
      @(posedge clk);
      #1;
    end
    if (ctl !== exp) begin
      chk("ctl wait", ctl, exp);
      summarize();
    end
    @(posedge clk);
  endtask
  // Sleep released first, enable raised only afterwards
  task automatic t_powerup();
    wr_reg(REG_CTRL, 8'h01);
    wait_ctl(2'b10);
    wait_ctl(2'b11);
    rd_reg(REG_STATUS, r);
    chk("status run", r, 8'h30);
  endtask
  // Every drive code; both-high pair must never reach the pins
  task automatic t_decode();
    logic [1:0] a, b;
    logic [7:0] e;
    for (int d = 0; d < 16; d++) begin
      a = d[1:0] & ~d[3:2];
      b = d[3:2] & ~d[1:0];
      wr_reg(REG_DRIVE, 8'(d));
      repeat (3) @(posedge clk);
      chk("drive pins", 8'(drive_inputs), {4'h0, a, b});
      for (int c = 0; c < 2; c++)
        e[c*4+:4] = a[c] ? 4'h9 : (b[c] ? 4'h6 : 4'h3);
      chk("switches", sw, e);
    end
  endtask
  // Latched fault, then rearm through an enable low pulse
  task automatic t_fault();
    fault_req <= 1'b1;
    wait_ctl(2'b10);
    chk("drive off", 8'(drive_inputs), 8'h0);
    rd_reg(REG_STATUS, r);
    chk("status fault", r, 8'h41);
    fault_req <= 1'b0;
    // Let the released pin clear the synchroniser, else the set wins
    repeat (3) @(posedge clk);
    wr_reg(REG_STATUS, 8'h01);
    wr_reg(REG_CTRL, 8'h05);
    wait_ctl(2'b11);
    rd_reg(REG_STATUS, r);
    chk("status rearm", r, 8'h30);
  endtask
  // Auto mode: host keeps enable, then recovery through a latched fault and retry
  task automatic t_auto();
    wr_reg(REG_CTRL, 8'h03);
    fault_req <= 1'b1;
    repeat (4) @(posedge clk);
    chk("auto pins", 8'(ctl), 8'h03);
    fault_req <= 1'b0;
    wr_reg(REG_CTRL, 8'h05);
    wait_ctl(2'b10);
    wait_ctl(2'b11);
    repeat (3) @(posedge clk);
    wr_reg(REG_STATUS, 8'h01);
    rd_reg(REG_STATUS, r);
    chk("status auto", r, 8'h30);
  endtask
  // Warning is live, then supply loss drops every pin
  task automatic t_warn_supply();
    hot <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(REG_STATUS, r);
    chk("status warn", r, 8'h32);
    hot <= 1'b0;
    rd_reg(4'h7, r);
    chk("unmapped", r, 8'h00);
    supply_good <= 1'b0;
    wait_ctl(2'b00);
    chk("drive off", 8'(drive_inputs), 8'h0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    chk("ctl in reset", 8'(ctl), 8'h0);
    reset <= 1'b0;
    @(posedge clk);
    t_powerup();
    t_decode();
    t_fault();
    t_auto();
    t_warn_supply();
    summarize();
  end
endmodule
`default_nettype wire
